// file: hw/sre_map.svh
// constants shared by both ends of the serial io expansion link
// assumes a 20 MHz core clock on both ends; included by bare name
`ifndef SRE_MAP_SVH
`define SRE_MAP_SVH

// ************************************************************
// widths and link timing
// ************************************************************
`define SRE_WIDTH          8
`define SRE_CORE_CLK_NS    50
`define SRE_LINK_HALF_NS   400
`define SRE_LINK_HALF_CYC  ((`SRE_LINK_HALF_NS + `SRE_CORE_CLK_NS - 1) / `SRE_CORE_CLK_NS)
`define SRE_POR_NS         4000
`define SRE_POR_CYC        ((`SRE_POR_NS + `SRE_CORE_CLK_NS - 1) / `SRE_CORE_CLK_NS)
`define SRE_SIPO_PULSES    8
`define SRE_LATCH_PULSES   9
`define SRE_PISO_PULSES    7

// ************************************************************
// synchroniser bit positions inside the device
// ************************************************************
`define SRE_IX_SIPO_CLK    0
`define SRE_IX_DATA_A      1
`define SRE_IX_DATA_B      2
`define SRE_IX_CLEAR_N     3
`define SRE_IX_PISO_CLK    4
`define SRE_IX_INHIBIT     5
`define SRE_IX_LOAD_N      6
`define SRE_IX_PISO_SER    7
`define SRE_IX_SHIFT_CLK   8
`define SRE_IX_LATCH_CLK   9
`define SRE_IX_LATCH_SER   10
`define SRE_IX_OUT_EN_N    11
`define SRE_SYNC_BITS      12

// ************************************************************
// controller registers (wishbone byte addresses)
// ************************************************************
`define SRE_REG_CTRL       8'h00
`define SRE_REG_SIPO_DATA  8'h04
`define SRE_REG_LATCH_DATA 8'h08
`define SRE_REG_PISO_DATA  8'h0C
`define SRE_REG_STATUS     8'h10
`define SRE_CTRL_GO_SIPO   0
`define SRE_CTRL_GO_LATCH  1
`define SRE_CTRL_GO_PISO   2
`define SRE_STAT_BUSY      0
`define SRE_STAT_INIT_DONE 1
`define SRE_RESET_DATA     8'h00
`endif

// file: hw/sre_pkg.sv
// types shared by the serial io expansion ends
// assumes nothing beyond a systemverilog compiler
package sre_pkg;
  // controller sequencing states
  typedef enum logic [2:0] {
    SRE_ST_POR,
    SRE_ST_IDLE,
    SRE_ST_LOAD,
    SRE_ST_LOW,
    SRE_ST_HIGH
  } sre_state_type;

  // which transfer the sequencer is running
  typedef enum logic [1:0] {
    SRE_JOB_INIT,
    SRE_JOB_SIPO,
    SRE_JOB_LATCH,
    SRE_JOB_PISO
  } sre_job_type;
endpackage

// file: hw/sre_link_if.sv
// wires between the controller and the three shift registers
// assumes the bench supplies core_clk; no clocking blocks here
interface sre_link_if;
  logic sipo_clock;      // clock of the and-input register
  logic data_in_a;       // first and input
  logic data_in_b;       // second and input
  logic clear_n;         // clear of the and-input register
  logic piso_clock;      // clock of the parallel-in register
  logic clock_inhibit;   // inhibit of the parallel-in register
  logic shift_load_n;    // low loads the parallel inputs
  logic piso_serial_in;  // serial input of the parallel-in register
  logic shift_clock;     // shift clock of the latched register
  logic latch_clock;     // latch clock of the latched register
  logic serial_in;       // serial input of the latched register
  logic out_enable_n;    // low enables the latched outputs
  logic sipo_chain;      // last stage of the and-input register
  logic last_stage_out;  // last stage of the parallel-in register
  logic latch_chain;     // last stage of the latched register

  modport ctrl (
    output sipo_clock, data_in_a, data_in_b, clear_n, piso_clock, clock_inhibit,
    output shift_load_n, piso_serial_in, shift_clock, latch_clock, serial_in,
    output out_enable_n,
    input  sipo_chain, last_stage_out, latch_chain
  );
  modport dev (
    input  sipo_clock, data_in_a, data_in_b, clear_n, piso_clock, clock_inhibit,
    input  shift_load_n, piso_serial_in, shift_clock, latch_clock, serial_in,
    input  out_enable_n,
    output sipo_chain, last_stage_out, latch_chain
  );
endinterface

// file: hw/sre_device.sv
// the three 8-bit expansion shift registers, sampled on core_clk
// assumes link pins change far slower than core_clk (half period >= 4)
//
// What this block does
// - stages shift only on a rising clock edge
// - contents undefined until every stage written
// - controller shifts known values in at startup
// - output disable leaves stage values untouched
// - power-on disable lasts until init finished
// - and-register serial input is a AND b
// - and-register shifts and drops last stage
// - low clear zeroes every and-register stage
// - clear held low keeps outputs low
// - eight pulses; outputs follow stages at once
// - tie one and-input high for data
// - low load copies inputs, ignores clocks
// - rising clock or inhibit shifts, other low
// - load then seven pulses reads eight bits
// - shift clock shifts, output latch unchanged
// - latch clock copies stages, stages kept
// - tied clocks need nine pulses for eight
// - chain output comes from last stage
// - chain serial-in from upstream, share clocks
`include "sre_map.svh"
module sre_device
  import sre_pkg::*;
#(
  parameter int WIDTH = `SRE_WIDTH
) (
  input  wire logic             core_clk,          // system clock, 20 MHz
  input  wire logic             sys_rst,           // synchronous reset, high
  sre_link_if.dev               link,              // pins from the controller
  output logic [WIDTH-1:0]      sipo_q,            // and-register parallel outputs
  output logic                  sipo_valid,        // and-register fully written
  input  wire logic [WIDTH-1:0] piso_parallel_in,  // parallel-in register pins
  output logic                  piso_valid,        // parallel-in register written
  output logic [WIDTH-1:0]      latch_q,           // latched outputs
  output logic                  latch_q_oe,        // latched outputs driven
  output logic                  latch_valid        // latched outputs fully written
);
  import sre_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // move every stage up one place, new bit enters stage 0
  function automatic logic [WIDTH-1:0] shift_in(input logic [WIDTH-1:0] v,
                                                input logic             b);
    shift_in = {v[WIDTH-2:0], b};
  endfunction

  // count written stages up to the width, then hold
  function automatic logic [3:0] fill_inc(input logic [3:0] c);
    fill_inc = (c >= 4'(WIDTH)) ? c : c + 4'h1;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [`SRE_SYNC_BITS-1:0] sync1;
  logic [`SRE_SYNC_BITS-1:0] sync2;
  logic [`SRE_SYNC_BITS-1:0] prev;
  logic [WIDTH-1:0]          par1;
  logic [WIDTH-1:0]          par2;
  logic [`SRE_SYNC_BITS-1:0] pins;
  logic [`SRE_SYNC_BITS-1:0] rise;

  // pack the link pins so one two-stage chain covers them all
  always_comb
  begin
    pins                     = '0;
    pins[`SRE_IX_SIPO_CLK]   = link.sipo_clock;
    pins[`SRE_IX_DATA_A]     = link.data_in_a;
    pins[`SRE_IX_DATA_B]     = link.data_in_b;
    pins[`SRE_IX_CLEAR_N]    = link.clear_n;
    pins[`SRE_IX_PISO_CLK]   = link.piso_clock;
    pins[`SRE_IX_INHIBIT]    = link.clock_inhibit;
    pins[`SRE_IX_LOAD_N]     = link.shift_load_n;
    pins[`SRE_IX_PISO_SER]   = link.piso_serial_in;
    pins[`SRE_IX_SHIFT_CLK]  = link.shift_clock;
    pins[`SRE_IX_LATCH_CLK]  = link.latch_clock;
    pins[`SRE_IX_LATCH_SER]  = link.serial_in;
    pins[`SRE_IX_OUT_EN_N]   = link.out_enable_n;
  end

  // first stage feeds only the second; clear, load and enable idle high
  // so no false load or edge is seen as reset lets go
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync1 <= 12'h848;
      sync2 <= 12'h848;
      prev  <= 12'h848;
      par1  <= '0;
      par2  <= '0;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
      prev  <= sync2;
      par1  <= piso_parallel_in;
      par2  <= par1;
    end
  end

  // rising edges seen on core_clk after synchronisation
  assign rise = sync2 & ~prev;

  // ************************************************************
  // and-input serial-in parallel-out register
  // ************************************************************
  logic [WIDTH-1:0] sipo_stage;
  logic [WIDTH-1:0] next_sipo_stage;
  logic [3:0]       sipo_fill;
  logic [3:0]       next_sipo_fill;
  logic             sipo_bit;

  assign sipo_bit = sync2[`SRE_IX_DATA_A] & sync2[`SRE_IX_DATA_B];

  // clear dominates the clock; a held clear keeps every stage low
  always_comb
  begin
    next_sipo_stage = sipo_stage;
    next_sipo_fill  = sipo_fill;
    if (!sync2[`SRE_IX_CLEAR_N])
    begin
      next_sipo_stage = '0;
      next_sipo_fill  = 4'(WIDTH);
    end
    else if (rise[`SRE_IX_SIPO_CLK])
    begin
      next_sipo_stage = shift_in(sipo_stage, sipo_bit);
      next_sipo_fill  = fill_inc(sipo_fill);
    end
  end

  // ************************************************************
  // parallel-in serial-out register
  // ************************************************************
  logic [WIDTH-1:0] piso_stage;
  logic [WIDTH-1:0] next_piso_stage;
  logic [3:0]       piso_fill;
  logic [3:0]       next_piso_fill;
  logic             piso_step;

  // either input may act as the clock while the other rests low
  assign piso_step = (rise[`SRE_IX_PISO_CLK] & ~sync2[`SRE_IX_INHIBIT])
                   | (rise[`SRE_IX_INHIBIT] & ~sync2[`SRE_IX_PISO_CLK]);

  // load level wins over both clock inputs
  always_comb
  begin
    next_piso_stage = piso_stage;
    next_piso_fill  = piso_fill;
    if (!sync2[`SRE_IX_LOAD_N])
    begin
      next_piso_stage = par2;
      next_piso_fill  = 4'(WIDTH);
    end
    else if (piso_step)
    begin
      next_piso_stage = shift_in(piso_stage, sync2[`SRE_IX_PISO_SER]);
      next_piso_fill  = fill_inc(piso_fill);
    end
  end

  // ************************************************************
  // latched serial-in parallel-out register
  // ************************************************************
  logic [WIDTH-1:0] latch_stage;
  logic [WIDTH-1:0] next_latch_stage;
  logic [WIDTH-1:0] latch_hold;
  logic [WIDTH-1:0] next_latch_hold;
  logic [3:0]       latch_fill;
  logic [3:0]       next_latch_fill;
  logic             hold_valid;
  logic             next_hold_valid;

  // with the clocks tied the old stages reach the hold first, so the
  // outputs lag by one pulse and nine pulses land eight bits
  always_comb
  begin
    next_latch_stage = latch_stage;
    next_latch_hold  = latch_hold;
    next_latch_fill  = latch_fill;
    next_hold_valid  = hold_valid;
    if (rise[`SRE_IX_LATCH_CLK])
    begin
      next_latch_hold = latch_stage;
      next_hold_valid = (latch_fill >= 4'(WIDTH));
    end
    if (rise[`SRE_IX_SHIFT_CLK])
    begin
      next_latch_stage = shift_in(latch_stage, sync2[`SRE_IX_LATCH_SER]);
      next_latch_fill  = fill_inc(latch_fill);
    end
  end

  // ************************************************************
  // stage registers
  // ************************************************************
  // reset gives known zeros, but validity stays low until written
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sipo_stage  <= '0;
      sipo_fill   <= 4'h0;
      piso_stage  <= '0;
      piso_fill   <= 4'h0;
      latch_stage <= '0;
      latch_hold  <= '0;
      latch_fill  <= 4'h0;
      hold_valid  <= 1'b0;
    end
    else
    begin
      sipo_stage  <= next_sipo_stage;
      sipo_fill   <= next_sipo_fill;
      piso_stage  <= next_piso_stage;
      piso_fill   <= next_piso_fill;
      latch_stage <= next_latch_stage;
      latch_hold  <= next_latch_hold;
      latch_fill  <= next_latch_fill;
      hold_valid  <= next_hold_valid;
    end
  end

  // ************************************************************
  // outputs, each from its own flip-flop
  // ************************************************************
  // in step with the stages, taken from their next values; the enable gates only the driver,
  // never the hold, so a disabled output keeps its contents
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sipo_q              <= '0;
      sipo_valid          <= 1'b0;
      piso_valid          <= 1'b0;
      latch_q             <= '0;
      latch_q_oe          <= 1'b0;
      latch_valid         <= 1'b0;
      link.sipo_chain     <= 1'b0;
      link.last_stage_out <= 1'b0;
      link.latch_chain    <= 1'b0;
    end
    else
    begin
      sipo_q              <= next_sipo_stage;
      sipo_valid          <= (next_sipo_fill >= 4'(WIDTH));
      piso_valid          <= (next_piso_fill >= 4'(WIDTH));
      latch_q             <= next_latch_hold;
      latch_q_oe          <= ~sync2[`SRE_IX_OUT_EN_N];
      latch_valid         <= next_hold_valid;
      link.sipo_chain     <= next_sipo_stage[WIDTH-1];
      link.last_stage_out <= next_piso_stage[WIDTH-1];
      link.latch_chain    <= next_latch_stage[WIDTH-1];
    end
  end
endmodule

// file: hw/sre_controller.sv
// system controller end: wishbone registers in, link pins out
// assumes classic wishbone on core_clk; link pins reach the device
`include "sre_map.svh"
module sre_controller
  import sre_pkg::*;
#(
  parameter int HALF_CYC = `SRE_LINK_HALF_CYC,
  parameter int POR_CYC  = `SRE_POR_CYC
) (
  input  wire logic        core_clk,  // system clock, 20 MHz
  input  wire logic        sys_rst,   // synchronous reset, high
  sre_link_if.ctrl         link,      // pins to the device
  input  wire logic        wb_cyc_i,  // wishbone cycle
  input  wire logic        wb_stb_i,  // wishbone strobe
  input  wire logic        wb_we_i,   // wishbone write
  input  wire logic [7:0]  wb_adr_i,  // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,  // wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,  // wishbone write data
  output logic [31:0]      wb_dat_o,  // wishbone read data
  output logic             wb_ack_o   // wishbone acknowledge
);
  import sre_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  sre_state_type state;
  sre_state_type next_state;
  sre_job_type   job;
  sre_job_type   next_job;
  logic [15:0]   timer;
  logic [15:0]   next_timer;
  logic [3:0]    pulses;
  logic [3:0]    next_pulses;
  logic [8:0]    tx;
  logic [8:0]    next_tx;
  logic [7:0]    sipo_data;
  logic [7:0]    next_sipo_data;
  logic [7:0]    latch_data;
  logic [7:0]    next_latch_data;
  logic [7:0]    piso_data;
  logic [7:0]    next_piso_data;
  logic          init_done;
  logic          next_init_done;
  logic          next_ack;
  logic [31:0]   next_dat;
  logic          ret1;
  logic          ret2;
  logic          wr;
  logic          go_hit;

  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign go_hit = wr & (wb_adr_i == `SRE_REG_CTRL) & (state == SRE_ST_IDLE);

  // returning serial bit crosses from the device through two flops
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ret1 <= 1'b0;
      ret2 <= 1'b0;
    end
    else
    begin
      ret1 <= link.last_stage_out;
      ret2 <= ret1;
    end
  end

  // ************************************************************
  // wishbone slave, ack one cycle after the strobe
  // ************************************************************
  always_comb
  begin
    next_ack        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat        = 32'h0000_0000;
    next_sipo_data  = sipo_data;
    next_latch_data = latch_data;
    if (wr && wb_adr_i == `SRE_REG_SIPO_DATA)
      next_sipo_data = wb_dat_i[7:0];
    if (wr && wb_adr_i == `SRE_REG_LATCH_DATA)
      next_latch_data = wb_dat_i[7:0];
    case (wb_adr_i)
      `SRE_REG_SIPO_DATA:  next_dat = {24'h000000, sipo_data};
      `SRE_REG_LATCH_DATA: next_dat = {24'h000000, latch_data};
      `SRE_REG_PISO_DATA:  next_dat = {24'h000000, piso_data};
      `SRE_REG_STATUS:     next_dat = {30'h0, init_done, state != SRE_ST_IDLE};
      default:             next_dat = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // link sequencer
  // ************************************************************
  // data changes only while the clock is low, so the device always
  // sees it settled a full half period before the rising edge
  always_comb
  begin
    next_state     = state;
    next_job       = job;
    next_timer     = (timer == 16'h0000) ? 16'h0000 : timer - 16'h0001;
    next_pulses    = pulses;
    next_tx        = tx;
    next_piso_data = piso_data;
    next_init_done = init_done;
    case (state)
      SRE_ST_POR:
        if (timer == 16'h0000)
        begin
          next_state  = SRE_ST_LOW;
          next_job    = SRE_JOB_INIT;
          next_pulses = 4'(`SRE_LATCH_PULSES);
          next_tx     = 9'h000;
          next_timer  = 16'(HALF_CYC - 1);
        end
      SRE_ST_IDLE:
        if (go_hit)
        begin
          next_timer = 16'(HALF_CYC - 1);
          next_state = SRE_ST_LOW;
          if (wb_dat_i[`SRE_CTRL_GO_PISO])
          begin
            next_job    = SRE_JOB_PISO;
            next_pulses = 4'(`SRE_PISO_PULSES + 1);
            next_state  = SRE_ST_LOAD;
          end
          else if (wb_dat_i[`SRE_CTRL_GO_LATCH])
          begin
            next_job    = SRE_JOB_LATCH;
            next_pulses = 4'(`SRE_LATCH_PULSES);
            next_tx     = {latch_data, 1'b0};
          end
          else if (wb_dat_i[`SRE_CTRL_GO_SIPO])
          begin
            next_job    = SRE_JOB_SIPO;
            next_pulses = 4'(`SRE_SIPO_PULSES);
            next_tx     = {sipo_data, 1'b0};
          end
          else
            next_state = SRE_ST_IDLE;
        end
      SRE_ST_LOAD:
        if (timer == 16'h0000)
        begin
          next_state = SRE_ST_LOW;
          next_timer = 16'(HALF_CYC - 1);
        end
      SRE_ST_LOW:
        if (timer == 16'h0000)
        begin
          next_timer  = 16'(HALF_CYC - 1);
          next_pulses = pulses - 4'h1;
          next_state  = SRE_ST_HIGH;
          if (job == SRE_JOB_PISO)
          begin
            next_piso_data = {piso_data[6:0], ret2};
            if (pulses == 4'h1)
              next_state = SRE_ST_IDLE;
          end
        end
      SRE_ST_HIGH:
        if (timer == 16'h0000)
        begin
          next_timer = 16'(HALF_CYC - 1);
          next_tx    = {tx[7:0], 1'b0};
          next_state = (pulses == 4'h0) ? SRE_ST_IDLE : SRE_ST_LOW;
          if (pulses == 4'h0 && job == SRE_JOB_INIT)
            next_init_done = 1'b1;
        end
      default:
        next_state = SRE_ST_IDLE;
    endcase
  end

  // ************************************************************
  // registers and pins
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state              <= SRE_ST_POR;
      job                <= SRE_JOB_INIT;
      timer              <= 16'(POR_CYC - 1);
      pulses             <= 4'h0;
      tx                 <= 9'h000;
      sipo_data          <= `SRE_RESET_DATA;
      latch_data         <= `SRE_RESET_DATA;
      piso_data          <= `SRE_RESET_DATA;
      init_done          <= 1'b0;
      wb_ack_o           <= 1'b0;
      wb_dat_o           <= 32'h0000_0000;
      link.sipo_clock    <= 1'b0;
      link.data_in_a     <= 1'b0;
      link.data_in_b     <= 1'b1;
      link.clear_n       <= 1'b0;
      link.piso_clock    <= 1'b0;
      link.clock_inhibit <= 1'b0;
      link.shift_load_n  <= 1'b1;
      link.piso_serial_in <= 1'b0;
      link.shift_clock   <= 1'b0;
      link.latch_clock   <= 1'b0;
      link.serial_in     <= 1'b0;
      link.out_enable_n  <= 1'b1;
    end
    else
    begin
      state              <= next_state;
      job                <= next_job;
      timer              <= next_timer;
      pulses             <= next_pulses;
      tx                 <= next_tx;
      sipo_data          <= next_sipo_data;
      latch_data         <= next_latch_data;
      piso_data          <= next_piso_data;
      init_done          <= next_init_done;
      wb_ack_o           <= next_ack;
      wb_dat_o           <= next_dat;
      link.data_in_a     <= next_tx[8];
      link.data_in_b     <= 1'b1;
      link.clear_n       <= (next_state != SRE_ST_POR);
      link.sipo_clock    <= (next_state == SRE_ST_HIGH)
                          & (job == SRE_JOB_SIPO || job == SRE_JOB_INIT);
      link.shift_clock   <= (next_state == SRE_ST_HIGH)
                          & (job == SRE_JOB_LATCH || job == SRE_JOB_INIT);
      link.latch_clock   <= (next_state == SRE_ST_HIGH)
                          & (job == SRE_JOB_LATCH || job == SRE_JOB_INIT);
      link.piso_clock    <= (next_state == SRE_ST_HIGH) & (job == SRE_JOB_PISO);
      link.shift_load_n  <= (next_state != SRE_ST_LOAD);
      link.clock_inhibit <= 1'b0;
      link.piso_serial_in <= 1'b0;
      link.serial_in     <= next_tx[8];
      link.out_enable_n  <= ~next_init_done;
    end
  end
endmodule

// file: bench/sre_link_props.sv
// link checks between controller and device, instantiated beside the link
// assumes one core_clk domain with synchronous sys_rst
module sre_link_props (
  input wire logic core_clk,      // system clock
  input wire logic sys_rst,       // synchronous reset
  input wire logic sipo_clock,    // and-register clock
  input wire logic data_in_a,     // and input a
  input wire logic data_in_b,     // and input b
  input wire logic clear_n,       // clear of and-register
  input wire logic clock_inhibit, // parallel-in inhibit
  input wire logic shift_clock,   // latched shift clock
  input wire logic latch_clock,   // latched output clock
  input wire logic serial_in,     // latched serial data
  input wire logic out_enable_n,  // latched output enable
  input wire logic sipo_chain     // and-register last stage
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // pins only move while their clock is low, so the device never races
  a_tied_and_input: assert property (data_in_b) else $error("and input b low");
  a_sipo_data_held: assert property (sipo_clock && $past(sipo_clock) |-> $stable(data_in_a))
    else $error("data a moved in high half");
  a_ser_data_held: assert property (shift_clock && $past(shift_clock) |-> $stable(serial_in))
    else $error("serial data moved in high half");
  a_clocks_tied: assert property (latch_clock == shift_clock) else $error("clocks not tied");
  a_clear_zeroes: assert property ((!clear_n)[*6] |-> !sipo_chain)
    else $error("chain high under clear");
  a_por_disables: assert property (!clear_n |-> out_enable_n) else $error("outputs on in por");
  a_inhibit_low: assert property (!clock_inhibit) else $error("inhibit raised");
  a_pulse_width: assert property ($rose(shift_clock) |=> shift_clock[*5])
    else $error("short shift pulse");
endmodule

// file: bench/serial_io_expansion_shift_registers_tb.sv
// self-checking bench: controller and device joined over the link
// assumes the design files and sre_map.svh compile first
`include "sre_map.svh"
module serial_io_expansion_shift_registers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, sv, oe, pv, lv;
  logic [7:0]  adr = 8'h00, pin = 8'h00, sq, lq;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [7:0]  pat [3] = '{8'hA5, 8'hFF, 8'h01};
  int          fails = 0, checks = 0, cycles = 0;
  sre_link_if link ();
  always #25 core_clk = ~core_clk;
  sre_device u_sre_device (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .sipo_q(sq),
    .sipo_valid(sv), .piso_parallel_in(pin), .piso_valid(pv), .latch_q(lq), .latch_q_oe(oe),
    .latch_valid(lv));
  sre_controller #(.HALF_CYC(8), .POR_CYC(80)) u_sre_controller (.core_clk(core_clk),
    .sys_rst(sys_rst), .link(link), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  sre_link_props u_sre_link_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .sipo_clock(link.sipo_clock), .data_in_a(link.data_in_a), .data_in_b(link.data_in_b),
    .clear_n(link.clear_n), .clock_inhibit(link.clock_inhibit), .shift_clock(link.shift_clock),
    .latch_clock(link.latch_clock), .serial_in(link.serial_in),
    .out_enable_n(link.out_enable_n), .sipo_chain(link.sipo_chain));
  task summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  // one classic cycle; the request holds until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge core_clk); while (ack !== 1'b1 && n++ < 20);
    if (ack !== 1'b1) chk("ack", 32'h1, 32'(ack));
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // polls status; a short stall first lets a fresh go raise busy
  task wait_stat(input int b, input logic v);
    int n;
    n = 0;
    repeat (2) @(posedge core_clk);
    do wb(1'b0, `SRE_REG_STATUS, 32'h0); while (rd[b] !== v && n++ < 300);
    chk("status", 32'(v), 32'(rd[b]));
  endtask
  // a hang counts as a mismatch and closes the run
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("por_q", 32'h0, 32'(sq));
    chk("por_oe", 32'h0, 32'(oe));
    wait_stat(`SRE_STAT_INIT_DONE, 1'b1);
    // the enable pin needs its synchroniser and output flop to reach oe
    repeat (4) @(posedge core_clk);
    chk("init_oe", 32'h1, 32'(oe));
    chk("init_q", 32'h0, 32'(lq));
    $display("test init done");
    foreach (pat[i])
    begin
      wb(1'b1, `SRE_REG_SIPO_DATA, 32'(pat[i]));
      wb(1'b1, `SRE_REG_CTRL, 32'h1);
      wait_stat(`SRE_STAT_BUSY, 1'b0);
      chk("sipo_q", 32'(pat[i]), 32'(sq));
      chk("sipo_valid", 32'h1, 32'(sv));
      chk("sipo_chain", 32'(pat[i][7]), 32'(link.sipo_chain));
      wb(1'b1, `SRE_REG_LATCH_DATA, 32'(~pat[i]));
      wb(1'b1, `SRE_REG_CTRL, 32'h2);
      wait_stat(`SRE_STAT_BUSY, 1'b0);
      chk("latch_q", {24'h0, ~pat[i]}, 32'(lq));
      chk("latch_valid", 32'h1, 32'(lv));
      chk("latch_chain", {31'h0, ~pat[i][6]}, 32'(link.latch_chain));
      pin <= pat[i] ^ 8'h0F;
      wb(1'b1, `SRE_REG_CTRL, 32'h4);
      wait_stat(`SRE_STAT_BUSY, 1'b0);
      wb(1'b0, `SRE_REG_PISO_DATA, 32'h0);
      chk("piso_data", 32'(pat[i] ^ 8'h0F), rd);
      chk("piso_valid", 32'h1, 32'(pv));
      chk("piso_chain", 32'(pin[0]), 32'(link.last_stage_out));
      $display("test pattern %0d done", i);
    end
    wb(1'b1, 8'h14, 32'hFF);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b0, `SRE_REG_SIPO_DATA, 32'h0);
    chk("sipo_reg", 32'(pat[2]), rd);
    $display("test registers done");
    summarize();
  end
endmodule
